/* inc/serial_port_defs.svh */
// named constants of the three-wire serial configuration port
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// bit counter end values: 16 instruction bits, 8 bits per data byte
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_INSTR_LAST 4'hF
`define CNT_BYTE_LAST 4'h7

// instruction word layout
`define RW_BIT 15
`define ADDR_MSB 14

// address step for multibyte transfers
`define ADDR_STEP 15'h0001

// bit-order control: register 0x00, bit 6, reset value zero (msb first)
`define CFG_ADDR 15'h0000
`define LSB_FIRST_BIT 6
`define LSB_FIRST_RST 1'b0

// update bit that applies the tuning word and phase offsets (placement arbitrary)
`define FTW_UPD_ADDR 15'h0005
`define FTW_UPD_BIT 0

// synchroniser reset image {sclk, cs_n, sdio}: deselected, clock low
`define PIN_RST 3'h2

`endif

/* inc/serial_port_pkg.sv */
// types shared by the serial configuration port
package serial_port_pkg;

  // transfer phase of one communication cycle
  typedef enum logic {
    PH_INSTR,
    PH_DATA
  } phase_t;

  // the three link pins as seen by the block's clock
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
  } pin_sample_t;

endpackage

/* rtl/bit_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // the first stage feeds only the second stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

/* rtl/serial_port.sv */
// three-wire serial slave port giving a controller access to configuration registers
// Behaviour
// - first 16 rising serial clock edges of a cycle carry the instruction word
// - chip select high then low restarts at instruction phase, dropping partial transfers
// - instruction bit 15 high means read, low means write
// - instruction bits 14..0 give first address; later addresses made internally
// - each data transfer is one byte; more bytes follow while selected
// - written byte takes effect at its last bit; tuning word waits for update bit
// - every incoming bit is sampled on the serial clock rising edge
// - read data bits change on the serial clock falling edge
// - data pin is released whenever chip select is high
// - chip select is active low and frames the whole cycle
// - one shared pin carries data both ways
// - bit-order control is register 0x00 bit 6, resets to msb first
// - msb first: bits msb first, address decrements per byte
// - lsb first: bits lsb first, address increments per byte
// - multibyte address counts down toward 0x0000 or up toward 0x7FFF
`timescale 1ns/10ps
`include "serial_port_defs.svh"
module serial_port (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic [14:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  output logic lsb_first_o,
  output logic ftw_update_o
);

  serial_port_pkg::pin_sample_t pin_raw;
  serial_port_pkg::pin_sample_t pin_s;
  serial_port_pkg::phase_t phase_r;
  logic sclk_prev_r;
  logic [3:0] cnt_r;
  logic [15:0] instr_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic [14:0] addr_r;
  logic step_r;
  logic wr_r;
  logic rd_r;
  logic [7:0] wdata_r;
  logic lsb_r;
  logic ftw_upd_r;
  logic sdio_r;
  logic oe_r;

  // every pin passes two flops before any logic looks at it
  assign pin_raw = {sclk_i, cs_n_i, sdio_i};

  bit_sync #(
    .WIDTH(3),
    .RST_VAL(`PIN_RST)
  ) u_pin_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(pin_raw),
    .sync_o(pin_s)
  );

  // serial clock edges, seen only while selected
  wire selected = !pin_s.cs_n;
  wire rise = selected && pin_s.sclk && !sclk_prev_r;
  wire fall = selected && !pin_s.sclk && sclk_prev_r;
  wire din = pin_s.sdio;

  // bit order decides the shift direction of all words
  wire [15:0] instr_nxt = lsb_r ? {din, instr_r[15:1]} : {instr_r[14:0], din};
  wire [7:0] rx_nxt = lsb_r ? {din, rx_r[7:1]} : {rx_r[6:0], din};
  wire in_instr = phase_r == serial_port_pkg::PH_INSTR;
  wire in_data = phase_r == serial_port_pkg::PH_DATA;
  wire instr_done = rise && in_instr && cnt_r == `CNT_INSTR_LAST;
  wire byte_done = rise && in_data && cnt_r == `CNT_BYTE_LAST;

  // address generator: down in msb-first mode, up in lsb-first mode
  wire [14:0] addr_step = lsb_r ? addr_r + `ADDR_STEP : addr_r - `ADDR_STEP;

  // outgoing bit and shifted image for read data
  wire tx_first = lsb_r ? tx_r[0] : tx_r[7];
  wire [7:0] tx_shift = lsb_r ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
  wire drive_fall = fall && in_data && rw_r;

  // write decode for the bits this port keeps itself
  wire cfg_hit = wr_r && addr_r == `CFG_ADDR;
  wire ftw_hit = wr_r && addr_r == `FTW_UPD_ADDR && wdata_r[`FTW_UPD_BIT];

  // previous synchronised serial clock for edge detection
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= pin_s.sclk;
    end
  end

  // phase and bit counter; deselect always returns to the instruction start
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= serial_port_pkg::PH_INSTR;
      cnt_r <= `CNT_ZERO;
    end else if (!selected) begin
      phase_r <= serial_port_pkg::PH_INSTR;
      cnt_r <= `CNT_ZERO;
    end else if (instr_done) begin
      phase_r <= serial_port_pkg::PH_DATA;
      cnt_r <= `CNT_ZERO;
    end else if (byte_done) begin
      cnt_r <= `CNT_ZERO;
    end else if (rise) begin
      cnt_r <= cnt_r + `CNT_ONE;
    end
  end

  // instruction shifter, loaded on rising edges only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      instr_r <= 16'h0000;
    end else if (rise && in_instr) begin
      instr_r <= instr_nxt;
    end
  end

  // direction and start address latched at the 16th bit, then stepped per byte
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rw_r <= 1'b0;
      addr_r <= 15'h0000;
    end else if (instr_done) begin
      rw_r <= instr_nxt[`RW_BIT];
      addr_r <= instr_nxt[`ADDR_MSB:0];
    end else if (step_r) begin
      addr_r <= addr_step;
    end
  end

  // data byte shifter
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_r <= 8'h00;
    end else if (rise && in_data) begin
      rx_r <= rx_nxt;
    end
  end

  // byte completion: write strobe at the last bit, address steps the cycle after
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      step_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      step_r <= byte_done;
      wr_r <= byte_done && !rw_r;
      if (byte_done) begin
        wdata_r <= rx_nxt;
      end
    end
  end

  // read strobe for the first byte and for each following address
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_r <= 1'b0;
    end else begin
      rd_r <= (instr_done && instr_nxt[`RW_BIT]) || (step_r && rw_r);
    end
  end

  // read data is captured in the strobe cycle; needs sclk slow enough to land before the next fall
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_r <= 8'h00;
    end else if (rd_r) begin
      tx_r <= reg_rdata_i;
    end else if (drive_fall) begin
      tx_r <= tx_shift;
    end
  end

  // bit-order control kept locally since it steers this port's own shifting
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lsb_r <= `LSB_FIRST_RST;
    end else if (cfg_hit) begin
      lsb_r <= wdata_r[`LSB_FIRST_BIT];
    end
  end

  // tuning word and phase offsets apply only on the update bit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ftw_upd_r <= 1'b0;
    end else begin
      ftw_upd_r <= ftw_hit;
    end
  end

  // shared data pin: driven on falling edges of a read data phase only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sdio_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (!selected) begin
      sdio_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (drive_fall) begin
      sdio_r <= tx_first;
      oe_r <= 1'b1;
    end
  end

  // outputs straight from flops
  assign sdio_o = sdio_r;
  assign sdio_oe_o = oe_r;
  assign reg_addr_o = addr_r;
  assign reg_wdata_o = wdata_r;
  assign reg_wr_o = wr_r;
  assign reg_rd_o = rd_r;
  assign lsb_first_o = lsb_r;
  assign ftw_update_o = ftw_upd_r;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_instr_end;
    rise && in_instr && cnt_r == `CNT_INSTR_LAST;
  endsequence

  sequence seq_write_byte_end;
    rise && in_data && cnt_r == `CNT_BYTE_LAST && !rw_r;
  endsequence

  sequence seq_step;
    step_r ##1 1'b1;
  endsequence

  chk_deselect_release: assert property (!selected |=> !sdio_oe_o && in_instr && cnt_r == `CNT_ZERO)
    else $error("port not released or reset after deselect");

  chk_instr_length: assert property (seq_instr_end |=> in_data && cnt_r == `CNT_ZERO)
    else $error("data phase did not start after 16 instruction bits");

  chk_read_strobe: assert property (seq_instr_end |=> reg_rd_o == $past(instr_nxt[`RW_BIT]))
    else $error("read strobe does not follow instruction bit 15");

  chk_start_addr: assert property (seq_instr_end |=> reg_addr_o == $past(instr_nxt[`ADDR_MSB:0]))
    else $error("start address not taken from instruction");

  chk_write_byte: assert property (seq_write_byte_end |=> reg_wr_o && reg_wdata_o == $past(rx_nxt))
    else $error("write byte not presented at its last bit");

  chk_addr_down: assert property ((step_r && !lsb_first_o) ##0 seq_step |-> reg_addr_o == $past(reg_addr_o) - 15'h0001)
    else $error("address did not decrement in msb-first mode");

  chk_addr_up: assert property ((step_r && lsb_first_o) ##0 seq_step |-> reg_addr_o == $past(reg_addr_o) + 15'h0001)
    else $error("address did not increment in lsb-first mode");

  chk_drive_on_fall: assert property ($rose(sdio_oe_o) |-> $past(fall) && $past(in_data) && $past(rw_r))
    else $error("data pin driven outside a read falling edge");

  chk_sample_rise: assert property (selected && !rise && !$rose(pin_s.cs_n) |=> cnt_r == $past(cnt_r))
    else $error("bit counter moved without a rising edge");

  chk_bit_order: assert property (cfg_hit |=> lsb_first_o == $past(wdata_r[`LSB_FIRST_BIT]))
    else $error("bit-order control not updated by write to 0x00");

  chk_write_only: assert property (reg_wr_o |-> !sdio_oe_o ##1 !reg_wr_o)
    else $error("write strobe while driving or longer than one cycle");

endmodule

/* testbench/ctrl_model.sv */
// serial controller model driving the three-wire configuration link
`timescale 1ns/10ps
module ctrl_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sd_o,
  output logic sd_oe_o,
  input wire logic sd_i
);
  localparam int HALF = 160;
  logic [7:0] tx [4];
  logic [7:0] rx [4];
  // link idles deselected with the clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end
  // one cycle of nb bytes; a nonzero cut abandons it after that many bits
  task automatic frame(input logic rd, input logic [14:0] addr, input int nb, input int cut, input logic lsb);
    logic [15:0] ins;
    int n;
    int k;
    int b;
    int j;
    ins = {rd, addr};
    n = (cut > 0) ? cut : 16 + 8 * nb;
    // pin changes land as non-blocking updates, so flops sampling on the same edge see no race
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      k = (i < 16) ? 0 : i - 16;
      b = k / 8;
      j = lsb ? k % 8 : 7 - k % 8;
      sd_oe_o <= (i < 16) || !rd;
      sd_o <= (i < 16) ? ins[lsb ? i : 15 - i] : tx[b][j];
      #HALF sclk_o <= 1'b1;
      // read bits are taken late in the high phase, clear of the device's fall-edge update
      #(HALF - 10);
      if (rd && i >= 16) rx[b][j] = sd_i;
      #10 sclk_o <= 1'b0;
    end
    #HALF sd_oe_o <= 1'b0;
    cs_n_o <= 1'b1;
    #(4 * HALF);
  endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the three-wire serial configuration port
`timescale 1ns/10ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, m_d, m_oe, d_o, d_oe, rd, wr, lsb_first, ftw_upd, cur;
  logic last_r = 1'b0;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] mem [32];
  logic [14:0] qa [$];
  logic [7:0] qd [$];
  logic [14:0] qr [$];
  int fail_count = 0;
  int checks = 0;
  int ftw_seen = 0;
  int cs_hi = 0;
  // a line nobody drives toggles so a stale level cannot pass for data
  wire sdio_w = d_oe ? d_o : (m_oe ? m_d : ~last_r);
  wire [7:0] rdata = mem[addr[4:0]];

  always #20 clock = ~clock;

  serial_port serial_port_inst (.clock_i(clock), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w),
    .sdio_o(d_o), .sdio_oe_o(d_oe), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_rdata_i(rdata), .lsb_first_o(lsb_first), .ftw_update_o(ftw_upd));
  ctrl_model ctrl_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .sd_o(m_d), .sd_oe_o(m_oe), .sd_i(sdio_w));

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  function automatic logic [14:0] exp_addr(input logic [14:0] a, input int k);
    return cur ? a + 15'(k) : a - 15'(k);
  endfunction

  // log strobes and watch who drives the shared line
  always @(posedge clock) begin
    last_r <= sdio_w;
    cs_hi <= cs_n ? cs_hi + 1 : 0;
    if (wr) begin
      qa.push_back(addr);
      qd.push_back(wdata);
    end
    if (rd) qr.push_back(addr);
    if (ftw_upd) ftw_seen++;
    if (!rst && m_oe) cmp("drive during host bits", 0, d_oe);
    if (cs_hi > 5) cmp("drive while deselected", 0, d_oe);
  end

  task automatic wr_frame(input logic [14:0] a, input int nb, input logic [7:0] d0);
    qa.delete();
    qd.delete();
    ctrl_model_inst.tx[0] = d0;
    for (int k = 1; k < 4; k++) ctrl_model_inst.tx[k] = 8'($urandom);
    ctrl_model_inst.frame(1'b0, a, nb, 0, cur);
    cmp("write count", nb, qa.size());
    for (int k = 0; k < qa.size(); k++) begin
      cmp("write addr", exp_addr(a, k), qa[k]);
      cmp("write data", ctrl_model_inst.tx[k], qd[k]);
    end
  endtask

  // read strobes are logged with their address; a missing strobe reads back as unknown
  task automatic rd_frame(input logic [14:0] a, input int nb);
    qr.delete();
    ctrl_model_inst.frame(1'b1, a, nb, 0, cur);
    for (int k = 0; k < nb; k++) begin
      cmp("read addr", exp_addr(a, k), qr[k]);
      cmp("read data", mem[5'(exp_addr(a, k))], ctrl_model_inst.rx[k]);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // both bit orders: random multibyte traffic, tuning update, abandoned frames
  initial begin
    void'($urandom(32'hC9F52772));
    foreach (mem[i]) mem[i] = 8'($urandom);
    cur = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    cmp("order after reset", 0, lsb_first);
    for (int m = 0; m < 2; m++) begin
      wr_frame(15'h0000, 1, 8'(m << 6));
      cur = m[0];
      cmp("bit order", m, lsb_first);
      for (int t = 0; t < 4; t++) begin
        wr_frame(15'($urandom_range(32'h7FF0, 32'h0010)), $urandom_range(3, 1), 8'($urandom));
        rd_frame(15'($urandom_range(32'h7FF0, 32'h0010)), $urandom_range(3, 1));
      end
      for (int f = 0; f < 2; f++) begin
        ftw_seen = 0;
        wr_frame(15'h0005, 1, 8'(f));
        cmp("tuning update", f, ftw_seen);
      end
      // cut once inside the instruction and once inside the data byte
      for (int c = 10; c < 30; c += 11) begin
        qa.delete();
        ctrl_model_inst.frame(1'b0, 15'h0100, 1, c, cur);
        cmp("writes after cut", 0, qa.size());
      end
    end
    wr_frame(15'h0000, 1, 8'h00);
    cmp("order restored", 0, lsb_first);
    finish_test();
  end

  // cut a hang short well past the expected quarter millisecond of traffic
  initial begin
    #2000000;
    fail_count++;
    finish_test();
  end
endmodule
